// ---- rtl/sbank_top.sv ----
// Behaviour
// [R01] each access is one sixteen-bit frame: header byte then data byte
// [R02] header carries a seven-bit address plus one access mode bit
// [R03] mode bit 0 reads; the addressed register stays unchanged
// [R04] mode bit 1 writes the data byte into the addressed register
// [R05] register data bits 0..7 travel as frame bits 8..15
// [R06] power-on or soft reset loads every register with its reset value
// [R07] restart loads restart values; don't-care bits keep their contents
// [R08] bits are read-only, read/write, or read/write with hardware updates
// [R09] reserved bits read zero; writes to them are dropped
// [R10] plain control bits change only by writes; hardware bits may self-update
// [R11] a write answers with the value held before that write
// [R12] writes to read-only registers or bits have no effect
`timescale 1ns/1ps
`default_nettype none
module sbank_top
   import sbank_pkg::*;
#(
   parameter logic [DW-1:0] PART_ID = 8'h5a // arbitrary value
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic spi_sck,
   input wire logic spi_csn,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic [NFLAG-1:0][DW-1:0] flag_set,
   input wire logic [NLVL-1:0][DW-1:0] lvl_in,
   input wire logic restart_evt,
   input wire logic soft_rst,
   input wire logic mode_hw_we,
   input wire logic [DW-1:0] mode_hw_val,
   input wire logic fo_hw_set,
   output logic [DW-1:0] mode_ctrl,
   output logic [DW-1:0] hw_ctrl,
   output logic soft_rst_req,
   output logic wr_done,
   output logic rd_done
);
   // ****************************************
   // link side, on the serial clock
   // ****************************************
   logic [DW-1:0] hdr_l;
   logic [FRAME_BITS-1:0] word_l;
   logic hdr_tgl_l, frame_tgl_l;
   logic [DW-1:0] rd_byte_ff, nxt_rd_byte;

   sbank_link u_link (
      .spi_sck(spi_sck),
      .spi_csn(spi_csn),
      .nrst(nrst),
      .spi_mosi(spi_mosi),
      .rd_byte(rd_byte_ff),
      .hdr(hdr_l),
      .word(word_l),
      .hdr_tgl(hdr_tgl_l),
      .frame_tgl(frame_tgl_l),
      .spi_miso(spi_miso)
   );

   // the pin is driven for the whole time the device is selected
   assign spi_miso_oe = ~spi_csn;

   // ****************************************
   // crossing into the core clock
   // ****************************************
   logic hdr_pulse, frame_pulse;

   // toggles cross by synchroniser; the words they mark stay still for
   // at least eight serial clocks, so they are read without a sync chain
   sbank_sync #(.W(1)) u_sync_hdr (
      .clk(clk),
      .nrst(nrst),
      .d(hdr_tgl_l),
      .q(),
      .chg(hdr_pulse)
   );

   sbank_sync #(.W(1)) u_sync_frame (
      .clk(clk),
      .nrst(nrst),
      .d(frame_tgl_l),
      .q(),
      .chg(frame_pulse)
   );

   // ****************************************
   // command decode
   // ****************************************
   logic [AW-1:0] rd_addr, wr_addr;
   logic [DW-1:0] wr_data;
   logic wr_en;
   logic soft_all;

   always_comb begin
      rd_addr = hdr_l[AW-1:0]; // [R02]
      wr_addr = word_l[AW-1:0];
      wr_data = word_l[FRAME_BITS-1:DATA_LSB]; // [R05]
      wr_en = frame_pulse & word_l[RW_POS]; // [R03] [R04]
   end

   // ****************************************
   // internal soft reset from the mode field
   // ****************************************
   logic soft_int_ff, nxt_soft_int;

   // a written mode of 3 is executed one clock later as a soft reset
   always_comb begin
      nxt_soft_int = wr_en && wr_addr == A_MODE &&
                     wr_data[MODE_LSB+1:MODE_LSB] == MODE_SOFT;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         soft_int_ff <= 1'b0;
      end else begin
         soft_int_ff <= nxt_soft_int;
      end
   end

   assign soft_all = soft_rst | soft_int_ff;

   // ****************************************
   // status flags, cleared by a write
   // ****************************************
   logic [NFLAG-1:0][DW-1:0] flag_ff;

   genvar gi;
   generate
      for (gi = 0; gi < NFLAG; gi++) begin : g_flag
         logic [DW-1:0] nxt_flag;
         // clear by any write to the flag's own address; a same-cycle event still sets, so none is lost
         always_comb begin
            nxt_flag = flag_ff[gi];
            if (soft_all) begin
               nxt_flag = FLAG_RST; // [R06]
            end else if (wr_en && wr_addr == FLAG_ADDR[gi]) begin
               nxt_flag = FLAG_RST;
            end
            nxt_flag = (nxt_flag | flag_set[gi]) & FLAG_MASK[gi]; // [R08] [R09]
         end

         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               flag_ff[gi] <= FLAG_RST; // [R06]
            end else begin
               flag_ff[gi] <= nxt_flag;
            end
         end
      end
   endgenerate

   // ****************************************
   // control registers
   // ****************************************
   logic [DW-1:0] mode_ff, nxt_mode;
   logic [DW-1:0] hwc_ff, nxt_hwc;

   // priority: soft reset, restart, then hardware update, then spi write
   always_comb begin
      nxt_mode = mode_ff;
      nxt_hwc = hwc_ff;
      if (soft_all) begin
         nxt_mode = MODE_RST; // [R06]
         nxt_hwc = HWC_RST;
      end else if (restart_evt) begin
         nxt_mode = (mode_ff & MODE_RS_KEEP) | (MODE_RS_VAL & ~MODE_RS_KEEP); // [R07]
         nxt_hwc = (hwc_ff & HWC_RS_KEEP) | (HWC_RS_VAL & ~HWC_RS_KEEP); // [R07]
      end else begin
         // only spi writes touch plain bits; reserved bits stay zero
         if (wr_en && wr_addr == A_MODE) begin
            nxt_mode = (mode_ff & ~MODE_RW_MASK) | (wr_data & MODE_RW_MASK); // [R04] [R09] [R10]
         end
         if (wr_en && wr_addr == A_HWC) begin
            nxt_hwc = (hwc_ff & ~HWC_RW_MASK) | (wr_data & HWC_RW_MASK); // [R04] [R09] [R10]
         end
         // hardware may move only its own bits
         if (mode_hw_we) begin
            nxt_mode = (nxt_mode & ~MODE_HW_MASK) | (mode_hw_val & MODE_HW_MASK); // [R08] [R10]
         end
         if (fo_hw_set) begin
            nxt_hwc = nxt_hwc | HWC_FO_BIT; // [R08] [R10]
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_ff <= MODE_RST; // [R06]
         hwc_ff <= HWC_RST;
      end else begin
         mode_ff <= nxt_mode;
         hwc_ff <= nxt_hwc;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   logic [DW-1:0] rd_val;

   // unmapped addresses answer zero; level and id registers have no store
   always_comb begin
      rd_val = '0;
      if (rd_addr == A_MODE) begin
         rd_val = mode_ff;
      end
      if (rd_addr == A_HWC) begin
         rd_val = hwc_ff;
      end
      if (rd_addr == A_PART) begin
         rd_val = PART_ID; // [R12]
      end
      for (int i = 0; i < NFLAG; i++) begin
         if (rd_addr == FLAG_ADDR[i]) begin
            rd_val = flag_ff[i];
         end
      end
      for (int j = 0; j < NLVL; j++) begin
         if (rd_addr == LVL_ADDR[j]) begin
            rd_val = lvl_in[j] & LVL_MASK[j]; // [R09] [R12]
         end
      end
   end

   // snapshot taken at the header, long before the write lands at frame end,
   // so a write shifts out the old contents
   always_comb begin
      nxt_rd_byte = hdr_pulse ? rd_val : rd_byte_ff; // [R11]
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_byte_ff <= '0;
      end else begin
         rd_byte_ff <= nxt_rd_byte;
      end
   end

   // ****************************************
   // frame completion strobes
   // ****************************************
   logic wr_done_ff, rd_done_ff, nxt_wr_done, nxt_rd_done;

   always_comb begin
      nxt_wr_done = wr_en;
      nxt_rd_done = frame_pulse & ~word_l[RW_POS]; // [R03]
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_done_ff <= 1'b0;
         rd_done_ff <= 1'b0;
      end else begin
         wr_done_ff <= nxt_wr_done;
         rd_done_ff <= nxt_rd_done;
      end
   end

   assign mode_ctrl = mode_ff;
   assign hw_ctrl = hwc_ff;
   assign soft_rst_req = soft_int_ff;
   assign wr_done = wr_done_ff;
   assign rd_done = rd_done_ff;
endmodule : sbank_top
`default_nettype wire

// ---- rtl/sbank_pkg.sv ----
package sbank_pkg;
   // ****************************************
   // command frame layout
   // ****************************************
   localparam int FRAME_BITS = 16;
   localparam int AW = 7;
   localparam int DW = 8;
   localparam int CNT_W = 5;
   localparam int RW_POS = 7;
   localparam int DATA_LSB = 8;
   localparam logic [CNT_W-1:0] CNT_HDR = 5'h08;
   localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;

   // ****************************************
   // register map
   // ****************************************
   localparam int NFLAG = 10;
   localparam int NLVL = 4;
   localparam logic [AW-1:0] A_MODE = 7'h01;
   localparam logic [AW-1:0] A_HWC = 7'h02;
   localparam logic [AW-1:0] A_PART = 7'h7e;
   // flag order: supply_b, supply_a, thermal, device, bus_a, bus_b, wake_a, wake_b, sw_oc, sw_ol
   localparam logic [NFLAG-1:0][AW-1:0] FLAG_ADDR = {7'h55, 7'h54, 7'h47, 7'h46, 7'h45,
                                                     7'h44, 7'h43, 7'h42, 7'h41, 7'h40};
   localparam logic [NFLAG-1:0][DW-1:0] FLAG_MASK = {8'h0f, 8'h0f, 8'h30, 8'h37, 8'h00,
                                                     8'h1f, 8'hcf, 8'h07, 8'hff, 8'h43};
   localparam logic [DW-1:0] FLAG_RST = 8'h00;
   // level order: wake levels, selective wake state, error count, clock recovery average
   localparam logic [NLVL-1:0][AW-1:0] LVL_ADDR = {7'h72, 7'h71, 7'h70, 7'h48};
   localparam logic [NLVL-1:0][DW-1:0] LVL_MASK = {8'hff, 8'h3f, 8'h4f, 8'hf7};

   // ****************************************
   // control register layouts
   // ****************************************
   localparam logic [DW-1:0] MODE_RST = 8'h00;
   localparam logic [DW-1:0] MODE_RW_MASK = 8'hdf;
   localparam logic [DW-1:0] MODE_HW_MASK = 8'hdc;
   localparam logic [DW-1:0] MODE_RS_KEEP = 8'h03;
   localparam logic [DW-1:0] MODE_RS_VAL = 8'h00;
   localparam int MODE_LSB = 6;
   localparam logic [1:0] MODE_SOFT = 2'h3;
   localparam logic [DW-1:0] HWC_RST = 8'h00;
   localparam logic [DW-1:0] HWC_RW_MASK = 8'h61;
   localparam logic [DW-1:0] HWC_HW_MASK = 8'h20;
   localparam logic [DW-1:0] HWC_RS_KEEP = 8'h41;
   localparam logic [DW-1:0] HWC_RS_VAL = 8'h00;
   localparam logic [DW-1:0] HWC_FO_BIT = 8'h20;
endpackage : sbank_pkg

// ---- rtl/sbank_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbank_sync
   import sbank_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic chg
);
   logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff, nxt_q;
   logic chg_ff, nxt_chg;

   // accept a new value only once stages two and three agree
   always_comb begin
      nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;
      nxt_chg = |(nxt_q ^ q_ff);
   end

   // s1 feeds only s2, to keep metastability away from logic
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff <= '0;
         chg_ff <= 1'b0;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff <= nxt_q;
         chg_ff <= nxt_chg;
      end
   end

   assign q = q_ff;
   assign chg = chg_ff;
endmodule : sbank_sync
`default_nettype wire

// ---- rtl/sbank_link.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbank_link
   import sbank_pkg::*;
(
   input wire logic spi_sck,
   input wire logic spi_csn,
   input wire logic nrst,
   input wire logic spi_mosi,
   input wire logic [DW-1:0] rd_byte,
   output logic [DW-1:0] hdr,
   output logic [FRAME_BITS-1:0] word,
   output logic hdr_tgl,
   output logic frame_tgl,
   output logic spi_miso
);
   // ****************************************
   // frame shifter, cleared while chip select is high
   // ****************************************
   logic frm_rst_n;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [FRAME_BITS-1:0] sh_ff, nxt_sh;
   logic [DW-1:0] hdr_ff, nxt_hdr;
   logic [FRAME_BITS-1:0] word_ff, nxt_word;
   logic hdr_tgl_ff, nxt_hdr_tgl, frame_tgl_ff, nxt_frame_tgl;
   logic [DW-1:0] osh_ff, nxt_osh;
   logic miso_ff, nxt_miso;

   assign frm_rst_n = nrst & ~spi_csn;

   // lsb first; count saturates so stray extra clocks do nothing
   always_comb begin
      nxt_sh = {spi_mosi, sh_ff[FRAME_BITS-1:1]};
      nxt_cnt = (cnt_ff == CNT_FULL) ? cnt_ff : cnt_ff + 5'h01;
   end

   always_ff @(posedge spi_sck or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         cnt_ff <= '0;
         sh_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
      end
   end

   // ****************************************
   // words handed to the core clock, held until the next frame
   // ****************************************
   // header after 8 bits, full command after exactly 16 [R01] [R02]
   always_comb begin
      nxt_hdr = hdr_ff;
      nxt_hdr_tgl = hdr_tgl_ff;
      nxt_word = word_ff;
      nxt_frame_tgl = frame_tgl_ff;
      if (cnt_ff == CNT_HDR - 5'h01) begin
         nxt_hdr = nxt_sh[FRAME_BITS-1:DATA_LSB];
         nxt_hdr_tgl = ~hdr_tgl_ff;
      end
      if (cnt_ff == CNT_FULL - 5'h01) begin
         nxt_word = nxt_sh; // [R05]
         nxt_frame_tgl = ~frame_tgl_ff;
      end
   end

   // toggles survive chip select so no event is lost in the crossing
   always_ff @(posedge spi_sck or negedge nrst) begin
      if (!nrst) begin
         hdr_ff <= '0;
         hdr_tgl_ff <= 1'b0;
         word_ff <= '0;
         frame_tgl_ff <= 1'b0;
      end else begin
         hdr_ff <= nxt_hdr;
         hdr_tgl_ff <= nxt_hdr_tgl;
         word_ff <= nxt_word;
         frame_tgl_ff <= nxt_frame_tgl;
      end
   end

   // ****************************************
   // answer byte, shifted on falling edges
   // ****************************************
   // rd_byte is sampled once, half a clock after the header toggle
   always_comb begin
      nxt_osh = osh_ff;
      nxt_miso = 1'b0;
      if (cnt_ff == CNT_HDR) begin
         nxt_miso = rd_byte[0];
         nxt_osh = {1'b0, rd_byte[DW-1:1]};
      end else if (cnt_ff > CNT_HDR && cnt_ff < CNT_FULL) begin
         nxt_miso = osh_ff[0];
         nxt_osh = {1'b0, osh_ff[DW-1:1]};
      end
   end

   always_ff @(negedge spi_sck or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         osh_ff <= '0;
         miso_ff <= 1'b0;
      end else begin
         osh_ff <= nxt_osh;
         miso_ff <= nxt_miso;
      end
   end

   assign hdr = hdr_ff;
   assign word = word_ff;
   assign hdr_tgl = hdr_tgl_ff;
   assign frame_tgl = frame_tgl_ff;
   assign spi_miso = miso_ff;
endmodule : sbank_link
`default_nettype wire

// ---- test/sbank_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbank_top_monitor
   import sbank_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic spi_csn,
   input wire logic spi_miso_oe,
   input wire logic restart_evt,
   input wire logic soft_rst,
   input wire logic mode_hw_we,
   input wire logic [DW-1:0] mode_hw_val,
   input wire logic fo_hw_set,
   input wire logic [DW-1:0] mode_ctrl,
   input wire logic [DW-1:0] hw_ctrl,
   input wire logic soft_rst_req,
   input wire logic wr_done,
   input wire logic rd_done
);
   logic ev_d1_ff;
   logic ev_d2_ff;
   // recent hardware causes; a control change without one must come from a write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ev_d1_ff <= 1'h0;
         ev_d2_ff <= 1'h0;
      end else begin
         ev_d1_ff <= restart_evt | soft_rst | mode_hw_we | fo_hw_set | soft_rst_req;
         ev_d2_ff <= ev_d1_ff;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_write_soon;
      ##[0:2] wr_done;
   endsequence
   sequence s_reset_vals;
      ##[0:1] (mode_ctrl == MODE_RST && hw_ctrl == HWC_RST);
   endsequence
   property p_oe_sel;
      spi_miso_oe == !spi_csn;
   endproperty
   property p_done_excl;
      !(wr_done && rd_done);
   endproperty
   property p_wr_pulse;
      wr_done |=> !wr_done;
   endproperty
   property p_rd_pulse;
      rd_done |=> !rd_done;
   endproperty
   property p_reserved_zero;
      (mode_ctrl & ~MODE_RW_MASK) == 8'h00 && (hw_ctrl & ~HWC_RW_MASK) == 8'h00;
   endproperty
   property p_plain_bits;
      ($changed(mode_ctrl) || $changed(hw_ctrl)) |-> (ev_d1_ff || ev_d2_ff) or s_write_soon;
   endproperty
   property p_soft_load;
      soft_rst |=> mode_ctrl == MODE_RST && hw_ctrl == HWC_RST;
   endproperty
   property p_soft_by_write;
      soft_rst_req |-> s_reset_vals;
   endproperty
   property p_restart_load;
      restart_evt && !soft_rst |=> (mode_ctrl & ~MODE_RS_KEEP) == (MODE_RS_VAL & ~MODE_RS_KEEP)
         && (mode_ctrl & MODE_RS_KEEP) == ($past(mode_ctrl) & MODE_RS_KEEP)
         && (hw_ctrl & ~HWC_RS_KEEP) == (HWC_RS_VAL & ~HWC_RS_KEEP)
         && (hw_ctrl & HWC_RS_KEEP) == ($past(hw_ctrl) & HWC_RS_KEEP);
   endproperty
   property p_hw_update;
      mode_hw_we && !soft_rst && !restart_evt |=> (mode_ctrl & MODE_HW_MASK) == ($past(mode_hw_val) & MODE_HW_MASK);
   endproperty
   property p_fo_set;
      fo_hw_set && !soft_rst && !restart_evt |=> hw_ctrl[5];
   endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("miso enable not following select");
   a_done_excl: assert property (p_done_excl) else $error("read and write done together");
   a_wr_pulse: assert property (p_wr_pulse) else $error("write done longer than a cycle");
   a_rd_pulse: assert property (p_rd_pulse) else $error("read done longer than a cycle");
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved control bit set");
   a_plain_bits: assert property (p_plain_bits) else $error("control changed with no cause");
   a_soft_load: assert property (p_soft_load) else $error("soft reset values not loaded");
   a_soft_by_write: assert property (p_soft_by_write) else $error("mode write reset not loaded");
   a_restart_load: assert property (p_restart_load) else $error("restart values wrong");
   a_hw_update: assert property (p_hw_update) else $error("hardware mode update lost");
   a_fo_set: assert property (p_fo_set) else $error("failure output bit not set");
endmodule : sbank_top_monitor

bind sbank_top sbank_top_monitor mon_u (.clk(clk), .nrst(nrst), .spi_csn(spi_csn), .spi_miso_oe(spi_miso_oe),
   .restart_evt(restart_evt), .soft_rst(soft_rst), .mode_hw_we(mode_hw_we), .mode_hw_val(mode_hw_val),
   .fo_hw_set(fo_hw_set), .mode_ctrl(mode_ctrl), .hw_ctrl(hw_ctrl), .soft_rst_req(soft_rst_req),
   .wr_done(wr_done), .rd_done(rd_done));
`default_nettype wire

// ---- test/sbank_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbank_master (
   output logic spi_sck,
   output logic spi_csn,
   output logic spi_mosi,
   input wire logic spi_miso
);
   // idle: clock parked low, select high
   initial begin
      spi_sck = 1'h0;
      spi_csn = 1'h1;
      spi_mosi = 1'h0;
   end
   // one command, lsb first; odd start offset keeps phase unrelated to clk
   task automatic xfer(input logic [15:0] frame, output logic [7:0] ans);
      ans = 8'h00;
      #1.7;
      spi_csn = 1'h0;
      #62.5;
      for (int i = 0; i < 16; i++) begin
         spi_mosi = frame[i];
         #62.5;
         spi_sck = 1'h1;
         if (i >= 8) ans[i-8] = spi_miso;
         #62.5;
         spi_sck = 1'h0;
      end
      #62.5;
      spi_mosi = ~spi_mosi; // released line shows no stale value
      spi_csn = 1'h1;
      #125;
   endtask : xfer
endmodule : sbank_master
`default_nettype wire

// ---- test/test_sbank_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_sbank_top
   import sbank_pkg::*;
;
   localparam logic [DW-1:0] TB_PART = 8'h3c; // arbitrary value
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic spi_sck, spi_csn, spi_mosi, spi_miso, spi_miso_oe;
   logic [NFLAG-1:0][DW-1:0] flag_set = '0;
   logic [NLVL-1:0][DW-1:0] lvl_in = '0;
   logic restart_evt = 1'h0, soft_rst = 1'h0, mode_hw_we = 1'h0, fo_hw_set = 1'h0;
   logic [DW-1:0] mode_hw_val = 8'h00;
   logic [DW-1:0] mode_ctrl, hw_ctrl;
   logic soft_rst_req, wr_done, rd_done;
   int n_errors = 0, tests_run = 0, cycles = 0, n_wr = 0, n_rd = 0, x_wr = 0, x_rd = 0;
   int n_sr = 0, x_sr = 0;
   logic [7:0] m_mode, m_hw;
   logic [7:0] m_flag [NFLAG];

   sbank_top #(.PART_ID(TB_PART)) dut_u (.clk(clk), .nrst(nrst), .spi_sck(spi_sck), .spi_csn(spi_csn),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .flag_set(flag_set),
      .lvl_in(lvl_in), .restart_evt(restart_evt), .soft_rst(soft_rst), .mode_hw_we(mode_hw_we),
      .mode_hw_val(mode_hw_val), .fo_hw_set(fo_hw_set), .mode_ctrl(mode_ctrl), .hw_ctrl(hw_ctrl),
      .soft_rst_req(soft_rst_req), .wr_done(wr_done), .rd_done(rd_done));
   sbank_master mst_u (.spi_sck(spi_sck), .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

   always #2.5 clk = ~clk;

   // done pulses counted here since frames end long after them; cycle ceiling
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (wr_done === 1'h1) n_wr <= n_wr + 1;
      if (rd_done === 1'h1) n_rd <= n_rd + 1;
      if (soft_rst_req === 1'h1) n_sr <= n_sr + 1;
      if (cycles == 80000) begin
         n_errors++;
         stop_test();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      if (n_errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   // ****************************************
   // reference model
   // ****************************************
   function automatic void model_rst();
      m_mode = MODE_RST;
      m_hw = HWC_RST;
      foreach (m_flag[i]) m_flag[i] = FLAG_RST;
   endfunction : model_rst

   function automatic logic [7:0] rd_exp(input logic [6:0] a);
      logic [7:0] v;
      v = (a == A_MODE) ? m_mode : (a == A_HWC) ? m_hw : (a == A_PART) ? TB_PART : 8'h00;
      for (int i = 0; i < NFLAG; i++) if (a == FLAG_ADDR[i]) v = m_flag[i];
      for (int i = 0; i < NLVL; i++) if (a == LVL_ADDR[i]) v = lvl_in[i] & LVL_MASK[i];
      return v;
   endfunction : rd_exp

   function automatic void model_wr(input logic [6:0] a, input logic [7:0] d);
      if (a == A_MODE) m_mode = (m_mode & ~MODE_RW_MASK) | (d & MODE_RW_MASK);
      if (a == A_HWC) m_hw = (m_hw & ~HWC_RW_MASK) | (d & HWC_RW_MASK);
      for (int i = 0; i < NFLAG; i++) if (a == FLAG_ADDR[i]) m_flag[i] = 8'h00;
      if (a == A_MODE && d[7:6] == MODE_SOFT) begin
         model_rst();
         x_sr++;
      end
   endfunction : model_wr

   // ****************************************
   // stimulus tasks
   // ****************************************
   task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d);
      logic [7:0] ans;
      logic [7:0] exp;
      exp = rd_exp(a);
      if (wr) x_wr++;
      else x_rd++;
      if (wr) model_wr(a, d);
      @(posedge clk);
      mst_u.xfer({d, wr, a}, ans);
      chk(ans, exp, "answer byte");
      repeat (2) @(posedge clk);
      chk(mode_ctrl, m_mode, "mode reg");
      chk(hw_ctrl, m_hw, "hw reg");
      chk(8'(n_wr), 8'(x_wr), "write count");
      chk(8'(n_rd), 8'(x_rd), "read count");
      chk(8'(n_sr), 8'(x_sr), "soft reset request count");
   endtask : access

   task automatic hw_op(input int k);
      logic [79:0] v;
      v = 80'({$urandom, $urandom, $urandom});
      @(posedge clk);
      case (k)
         0: begin
            flag_set <= v;
            for (int i = 0; i < NFLAG; i++) m_flag[i] |= v[i*8+:8] & FLAG_MASK[i];
         end
         1: begin
            mode_hw_we <= 1'h1;
            mode_hw_val <= v[7:0];
            m_mode = (m_mode & ~MODE_HW_MASK) | (v[7:0] & MODE_HW_MASK);
         end
         2: begin
            fo_hw_set <= 1'h1;
            m_hw |= HWC_FO_BIT;
         end
         3: begin
            restart_evt <= 1'h1;
            m_mode = (m_mode & MODE_RS_KEEP) | (MODE_RS_VAL & ~MODE_RS_KEEP);
            m_hw = (m_hw & HWC_RS_KEEP) | (HWC_RS_VAL & ~HWC_RS_KEEP);
         end
         4: begin
            soft_rst <= 1'h1;
            model_rst();
         end
         default: lvl_in <= v[31:0];
      endcase
      @(posedge clk);
      flag_set <= '0;
      {mode_hw_we, fo_hw_set, restart_evt, soft_rst} <= 4'h0;
      repeat (4) @(posedge clk);
      chk(mode_ctrl, m_mode, "mode after event");
      chk(hw_ctrl, m_hw, "hw after event");
   endtask : hw_op

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [6:0] a;
      logic [6:0] q [$];
      void'($urandom(44));
      model_rst();
      repeat (20) @(posedge clk);
      nrst <= 1'h1;
      repeat (2) @(posedge clk);
      q = {A_MODE, A_HWC, A_PART, 7'h10, 7'h7f};
      for (int i = 0; i < NFLAG; i++) q.push_back(FLAG_ADDR[i]);
      for (int i = 0; i < NLVL; i++) q.push_back(LVL_ADDR[i]);
      hw_op(5);
      foreach (q[i]) access(1'h0, q[i], 8'($urandom));
      for (int k = 0; k < 6; k++) hw_op(k);
      access(1'h1, A_MODE, 8'h5b);
      hw_op(0);
      access(1'h1, A_MODE, 8'hc3);
      access(1'h0, FLAG_ADDR[1], 8'h00);
      repeat (70) begin
         a = q[$urandom % q.size()];
         case ($urandom % 3)
            0: access(1'h0, a, 8'($urandom));
            1: access(1'h1, a, 8'($urandom) & ((a == A_MODE) ? MODE_RW_MASK : (a == A_HWC) ? HWC_RW_MASK : 8'hff));
            default: hw_op($urandom % 6);
         endcase
      end
      stop_test();
   end
endmodule : test_sbank_top
`default_nettype wire
